//--- rtl/fscr_clock_recovery.v
// Fail-safe clock monitor recovery and start-up control with APB registers
// Function
// - Fail-safe ends only on reset or power-managed entry
// - After reset start configured oscillator with delays
// - Internal mux clocks device until primary ready
// - On ready switch to primary, set running flag
// - Monitoring resumes after switch back to primary
// - Never-ready primary leaves internal clock until power-managed entry
// - Control register keeps reset value while waiting
// - Power-managed entry selects control register source
// - Power-managed source stays monitored during mode
// - Failure with interrupt enabled: internal, no return
// - Idle failure, interrupt off: interrupt resumes internally
// - Clock, RC, internal modes monitor immediately
// - Crystal modes run internal until timers expire
// - Stable crystal: RC only samples the monitor
// - Crystal-mode oscillator never starting raises no fail flag
// - New power-managed mode while stabilising disables primary
// - Sample clock RC/64; latch set, cleared
// - Failure sets flag, switches internal, control unchanged
// - Failure clears watchdog counter and postscaler
// - Running flag one on primary, zero internal
`timescale 1ns/1ps
`default_nettype none
`include "fscr_defines.vh"

module fscr_clock_recovery (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Oscillator pins
  input wire primary_clk_pin,
  input wire secondary_clk_pin,
  // Clock and system control
  output reg [1:0] clk_sel_reg,
  output reg primary_osc_en_reg,
  output reg watchdog_clear_reg,
  output reg cpu_resume_reg,
  output reg fail_safe_reg
);

  // --------------------------------------
  // Notes
  // --------------------------------------
  // A primary that never starts in a crystal mode leaves the device on the internal clock
  // with no failure flagged; software has to time the start-up itself.
  // Mode entry while waiting turns the primary off and cancels the timer.
  // Hardware never rewrites the control register; its source field only
  // takes effect on the next power-managed entry.

  // --------------------------------------
  // Declarations
  // --------------------------------------
  reg [2:0] pri_sync_reg; // Primary pin sync and edge stage
  reg [2:0] sec_sync_reg; // Secondary pin sync and edge stage
  reg [7:0] osc_control_reg; // Software source select and flag
  reg [7:0] config_reg; // Mode, monitor and interrupt enables
  reg osc_fail_int_flag; // Sticky oscillator fail flag
  reg primary_clock_running_flag; // Primary supplies device clock
  reg clock_monitor_latch; // Set by device clock, cleared by sample
  reg monitor_on_reg; // Failure checking active
  reg waiting_reg; // Start-up in progress
  reg boot_reg; // Start-up owed after reset release
  reg [1:0] pm_mode_reg; // Current power-managed mode
  reg in_pm_reg; // A power-managed mode was entered
  reg idle_fail_reg; // Failure in idle with interrupt off
  reg [1:0] sel_next; // Next clock select
  wire sample_rise; // Sample clock rising edge
  wire sample_fall; // Sample clock falling edge
  wire timer_ready; // Start-up delays expired
  wire crystal_mode; // Mode needs start-up timer
  wire apb_wr; // Write in access phase
  wire [2:0] osc_mode; // Configured primary mode
  wire pri_fall; // Primary falling edge
  wire sec_fall; // Secondary falling edge
  wire mon_fall; // Falling edge of monitored clock
  wire fail_det; // Clock failure detected
  wire start_now; // Start-up begins this cycle
  wire pm_cmd; // Power-managed entry command
  wire wake_cmd; // Wake from sleep command
  wire irq_cmd; // Interrupt event command

  // Start-up configuration mode in the low config bits
  assign osc_mode = config_reg[2:0];
  // Crystal and resonator modes wait for the start-up timer
  assign crystal_mode = (osc_mode == `FSCR_MODE_LP) || (osc_mode == `FSCR_MODE_XT) ||
                        (osc_mode == `FSCR_MODE_HS) || (osc_mode == `FSCR_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE);
  // Only the completing access phase counts as a write
  assign apb_wr = psel && penable && pready && pwrite;
  // Command bits act once, on the completing write
  assign pm_cmd = apb_wr && (paddr == `FSCR_OFS_COMMAND) && pwdata[`FSCR_CMD_PM_BIT];
  assign wake_cmd = apb_wr && (paddr == `FSCR_OFS_COMMAND) && pwdata[`FSCR_CMD_WAKE_BIT];
  assign irq_cmd = apb_wr && (paddr == `FSCR_OFS_COMMAND) && pwdata[`FSCR_CMD_IRQ_BIT];
  // Falling edges taken behind the two-stage synchronisers
  assign pri_fall = pri_sync_reg[2] && !pri_sync_reg[1];
  assign sec_fall = sec_sync_reg[2] && !sec_sync_reg[1];
  // Monitored clock is whichever external source drives the device
  assign mon_fall = (clk_sel_reg == `FSCR_SRC_SECONDARY) ? sec_fall : pri_fall;
  // Failure: latch still clear at the sample fall, so no clock
  // edge came in the half period since the sample rise cleared it;
  // a healthy clock sets it again well before the fall
  assign fail_det = monitor_on_reg && config_reg[`FSCR_CFG_MON_EN_BIT] &&
                    sample_fall && !clock_monitor_latch;
  // Start-up after reset release or wake from sleep
  assign start_now = boot_reg || (wake_cmd && pm_mode_reg == `FSCR_PM_SLEEP);

  // --------------------------------------
  // Submodules
  // --------------------------------------
  // Free-running sample clock, one period per 64 clocks
  fscr_sample_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .sample_rise(sample_rise),
    .sample_fall(sample_fall)
  );

  // Start-up delays for crystal modes; mode entry cancels them
  fscr_startup_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_now && crystal_mode),
    .abort(pm_cmd),
    .use_pll(osc_mode == `FSCR_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE),
    .osc_edge(pri_fall),
    .ready(timer_ready)
  );

  // --------------------------------------
  // Pin synchronisers
  // --------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_sync_reg <= 3'h0;
      sec_sync_reg <= 3'h0;
    end else begin
      // Stage 0 feeds only stage 1
      // Stage 2 only delays stage 1 for the edge detector
      pri_sync_reg <= {pri_sync_reg[1:0], primary_clk_pin};
      sec_sync_reg <= {sec_sync_reg[1:0], secondary_clk_pin};
    end
  end

  // --------------------------------------
  // Clock monitor latch
  // --------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      clock_monitor_latch <= 1'b0;
    // A clock fall wins over the clear in the same cycle
    else if (mon_fall)
      clock_monitor_latch <= 1'b1;
    else if (sample_rise)
      clock_monitor_latch <= 1'b0;
  end

  // --------------------------------------
  // Clock select and recovery sequencing
  // --------------------------------------
  // Next source: failure first, then mode entry, then start-up steps
  always @* begin
    // Hold the present source unless an event moves it
    sel_next = clk_sel_reg;
    if (fail_det)
      sel_next = `FSCR_SRC_INTERNAL;
    else if (pm_cmd)
      sel_next = osc_control_reg[1:0];
    else if (start_now && crystal_mode)
      sel_next = `FSCR_SRC_INTERNAL;
    else if (start_now)
      sel_next = `FSCR_SRC_PRIMARY;
    else if (waiting_reg && timer_ready)
      sel_next = `FSCR_SRC_PRIMARY;
  end

  // Recovery state, updated on every rising clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= 1'b1;
      clk_sel_reg <= `FSCR_SRC_INTERNAL;
      primary_osc_en_reg <= 1'b0;
      waiting_reg <= 1'b0;
      monitor_on_reg <= 1'b0;
      fail_safe_reg <= 1'b0;
      primary_clock_running_flag <= 1'b0;
      watchdog_clear_reg <= 1'b0;
      pm_mode_reg <= `FSCR_PM_RUN;
      in_pm_reg <= 1'b0;
      idle_fail_reg <= 1'b0;
      cpu_resume_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b0;
      clk_sel_reg <= sel_next;
      // Running flag follows the live source
      primary_clock_running_flag <= (sel_next == `FSCR_SRC_PRIMARY);
      watchdog_clear_reg <= fail_det;
      cpu_resume_reg <= 1'b0;
      if (fail_det) begin
        // Enter fail-safe; control register untouched
        fail_safe_reg <= 1'b1;
        monitor_on_reg <= 1'b0;
        if (in_pm_reg && pm_mode_reg == `FSCR_PM_IDLE && !config_reg[`FSCR_CFG_INT_EN_BIT])
          idle_fail_reg <= 1'b1;
      end else if (pm_cmd) begin
        // Power-managed entry ends fail-safe and any start-up
        fail_safe_reg <= 1'b0;
        waiting_reg <= 1'b0;
        if (waiting_reg)
          primary_osc_en_reg <= 1'b0;
        else
          primary_osc_en_reg <= (osc_control_reg[1:0] == `FSCR_SRC_PRIMARY);
        monitor_on_reg <= (osc_control_reg[1:0] != `FSCR_SRC_INTERNAL);
        pm_mode_reg <= pwdata[2:1];
        in_pm_reg <= 1'b1;
        idle_fail_reg <= 1'b0;
      end else if (start_now) begin
        // Reset or wake: start the configured primary
        primary_osc_en_reg <= 1'b1;
        waiting_reg <= crystal_mode;
        monitor_on_reg <= !crystal_mode;
        pm_mode_reg <= `FSCR_PM_RUN;
        in_pm_reg <= 1'b0;
      end else if (waiting_reg && timer_ready) begin
        // Primary stable; RC returns to sampling only
        waiting_reg <= 1'b0;
        monitor_on_reg <= 1'b1;
      end
      // A primary that never readies leaves waiting set, on RC
      if (irq_cmd && idle_fail_reg) begin
        // Interrupt wakes the core on the internal clock
        cpu_resume_reg <= 1'b1;
        idle_fail_reg <= 1'b0;
        pm_mode_reg <= `FSCR_PM_RUN;
      end
    end
  end

  // --------------------------------------
  // Software registers
  // --------------------------------------
  // Command writes act as strobes; only a mode entry stores pwdata[2:1], in pm_mode_reg
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_control_reg <= `FSCR_OSC_CTRL_RST;
      config_reg <= `FSCR_CONFIG_RST;
      osc_fail_int_flag <= 1'b0;
    end else begin
      // Only software writes; hardware never rewrites it
      if (apb_wr && paddr == `FSCR_OFS_OSC_CTRL)
        osc_control_reg <= pwdata[7:0];
      if (apb_wr && paddr == `FSCR_OFS_CONFIG)
        config_reg <= pwdata[7:0];
      // Set wins over a write-one clear
      if (fail_det)
        osc_fail_int_flag <= 1'b1;
      else if (apb_wr && paddr == `FSCR_OFS_STATUS && pwdata[`FSCR_ST_FLAG_BIT])
        osc_fail_int_flag <= 1'b0;
    end
  end

  // --------------------------------------
  // APB answer, one wait-free access phase
  // --------------------------------------
  // Ready follows every setup cycle, so no access ever waits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `FSCR_OFS_OSC_CTRL: begin
            prdata <= {24'h000000, osc_control_reg[7:4], primary_clock_running_flag,
                       osc_control_reg[2:0]};
          end
          `FSCR_OFS_CONFIG: begin
            prdata <= {24'h000000, config_reg};
          end
          `FSCR_OFS_STATUS: begin
            prdata <= {27'h0000000, in_pm_reg, idle_fail_reg, waiting_reg, fail_safe_reg,
                       osc_fail_int_flag};
          end
          `FSCR_OFS_COMMAND: begin
            prdata <= {29'h00000000, pm_mode_reg, 1'b0};
          end
          default: begin
            // Unmapped address
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // fscr_clock_recovery
`default_nettype wire

//--- rtl/fscr_defines.vh
// Constants of the fail-safe clock recovery block
`ifndef FSCR_DEFINES_VH
`define FSCR_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FSCR_OFS_OSC_CTRL 12'h000
`define FSCR_OFS_CONFIG 12'h004
`define FSCR_OFS_STATUS 12'h008
`define FSCR_OFS_COMMAND 12'h00c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSCR_CTRL_SRC_LSB 0
`define FSCR_CTRL_RUN_BIT 3
`define FSCR_CFG_MON_EN_BIT 3
`define FSCR_CFG_INT_EN_BIT 4
`define FSCR_ST_FLAG_BIT 0
`define FSCR_CMD_PM_BIT 0
`define FSCR_CMD_WAKE_BIT 3
`define FSCR_CMD_IRQ_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSCR_OSC_CTRL_RST 8'h00
`define FSCR_CONFIG_RST 8'h19

// ----------------------------------------
// Oscillator modes of the start-up configuration
// ----------------------------------------
`define FSCR_MODE_LP 3'h0
`define FSCR_MODE_XT 3'h1
`define FSCR_MODE_HS 3'h2
`define FSCR_MODE_RC 3'h3
`define FSCR_MODE_EC 3'h4
`define FSCR_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE 3'h5
`define FSCR_MODE_INTERNAL_RC_OSC 3'h6

// ----------------------------------------
// Clock sources and power-managed modes
// ----------------------------------------
`define FSCR_SRC_PRIMARY 2'h0
`define FSCR_SRC_SECONDARY 2'h1
`define FSCR_SRC_INTERNAL 2'h2
`define FSCR_PM_RUN 2'h0
`define FSCR_PM_IDLE 2'h1
`define FSCR_PM_SLEEP 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSCR_SAMPLE_DIV 64
`define FSCR_OST_EDGES 1024
`define FSCR_CLK_NS 10
`define FSCR_PLL_LOCK_NS 2000
`define FSCR_PLL_LOCK_CYC ((`FSCR_PLL_LOCK_NS + `FSCR_CLK_NS - 1) / `FSCR_CLK_NS)

`endif

//--- rtl/fscr_sample_div.v
// Divider making the monitor sample clock from the internal RC clock
`timescale 1ns/1ps
`default_nettype none
`include "fscr_defines.vh"

module fscr_sample_div (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Sample clock edges
  output reg sample_rise,
  output reg sample_fall
);

  reg [5:0] div_reg; // Divide-by-64 counter

  // --------------------------------------
  // Counter and edge pulses
  // --------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 6'h00;
      sample_rise <= 1'b0;
      sample_fall <= 1'b0;
    end else begin
      div_reg <= div_reg + 6'h01;
      // Rise at count wrap, fall at mid count
      sample_rise <= (div_reg == 6'h3f);
      sample_fall <= (div_reg == 6'h1f);
    end
  end

endmodule // fscr_sample_div
`default_nettype wire

//--- rtl/fscr_startup_timer.v
// Start-up timer: oscillator edge count then PLL lock count
`timescale 1ns/1ps
`default_nettype none
`include "fscr_defines.vh"

module fscr_startup_timer (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire start,
  input wire abort,
  input wire use_pll,
  input wire osc_edge,
  // Result
  output reg ready
);

  reg [10:0] ost_reg; // Oscillator edges seen
  reg [15:0] pll_reg; // PLL lock cycles elapsed
  reg busy_reg; // Timing in progress

  // --------------------------------------
  // Two-stage timing sequence
  // --------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_reg <= 11'h000;
      pll_reg <= 16'h0000;
      busy_reg <= 1'b0;
      ready <= 1'b0;
    end else if (start || abort) begin
      // Restart or cancel
      ost_reg <= 11'h000;
      pll_reg <= 16'h0000;
      busy_reg <= start;
      ready <= 1'b0;
    end else if (busy_reg) begin
      if (ost_reg != `FSCR_OST_EDGES) begin
        // Count only real oscillator edges
        if (osc_edge)
          ost_reg <= ost_reg + 11'h001;
      end else if (use_pll && pll_reg != `FSCR_PLL_LOCK_CYC) begin
        pll_reg <= pll_reg + 16'h0001;
      end else begin
        busy_reg <= 1'b0;
        ready <= 1'b1;
      end
    end
  end

endmodule // fscr_startup_timer
`default_nettype wire

//--- test/fscr_clock_recovery_chk.sv
// Port checker of the clock recovery block
`timescale 1ns/1ps
`default_nettype none
module fscr_clock_recovery_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Clock control
  input wire logic [1:0] clk_sel_reg,
  input wire logic primary_osc_en_reg,
  input wire logic watchdog_clear_reg,
  input wire logic cpu_resume_reg,
  input wire logic fail_safe_reg
);
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  // Completed command write
  wire logic cmd_wr = psel && penable && pready && pwrite && (paddr == 12'h00c);
  wire logic pm_wr = cmd_wr && pwdata[0];
  wire logic irq_wr = cmd_wr && pwdata[4];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_FAIL_SWITCH: assert property ($rose(fail_safe_reg) |-> clk_sel_reg == 2'h2)
    else $error("failure did not select internal clock");
  AST_SAFE_INTERNAL: assert property (fail_safe_reg |-> clk_sel_reg == 2'h2)
    else $error("fail-safe left internal clock");
  AST_SAFE_EXIT: assert property ($fell(fail_safe_reg) |-> $past(pm_wr))
    else $error("fail-safe ended without mode entry");
  AST_WDT_CAUSE: assert property (watchdog_clear_reg |-> $rose(fail_safe_reg))
    else $error("watchdog clear without failure");
  AST_WDT_PULSE: assert property (watchdog_clear_reg |=> !watchdog_clear_reg)
    else $error("watchdog clear too long");
  AST_RESUME: assert property (cpu_resume_reg |-> $past(irq_wr) || $past(irq_wr, 2))
    else $error("resume without interrupt");
  AST_OSC_OFF: assert property ($fell(primary_osc_en_reg) |-> $past(pm_wr))
    else $error("oscillator off without mode entry");
  AST_ACK: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access not answered in one cycle");
  AST_ERR: assert property (pslverr |-> pready && paddr != 12'h000 && paddr != 12'h004 &&
    paddr != 12'h008 && paddr != 12'h00c)
    else $error("error on a mapped address");
  COV_FAIL: cover property ($rose(fail_safe_reg));
  COV_RESUME: cover property (cpu_resume_reg);
  COV_OSC_OFF: cover property ($fell(primary_osc_en_reg));
endmodule // fscr_clock_recovery_chk
`default_nettype wire

//--- test/fscr_clock_recovery_tb.sv
// Self-checking bench of the clock recovery block
`timescale 1ns/1ps
`default_nettype none
`include "fscr_defines.vh"
module fscr_clock_recovery_tb;
  // ----------------------------------------
  // Signals, clock, instances
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, last_err, prim_pin;
  logic osc_run = 1'b1;
  logic [1:0] clk_sel_reg;
  logic primary_osc_en_reg, watchdog_clear_reg, cpu_resume_reg, fail_safe_reg;
  int miscompares = 0;
  int total_checks = 0;
  // Free running 100 MHz clock
  always #5 pclk = ~pclk;
  fscr_clock_recovery dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .primary_clk_pin(prim_pin), .secondary_clk_pin(1'b0),
    .clk_sel_reg(clk_sel_reg), .primary_osc_en_reg(primary_osc_en_reg),
    .watchdog_clear_reg(watchdog_clear_reg), .cpu_resume_reg(cpu_resume_reg),
    .fail_safe_reg(fail_safe_reg));
  fscr_osc_model u_osc (.enable(primary_osc_en_reg), .running(osc_run), .osc_clk(prim_pin));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Bounded wait: 0 primary selected, 1 fail-safe, 2 resume
  task automatic wait_on(input int sel, input int lim);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge pclk);
      n++;
      hit = (sel == 0 && clk_sel_reg === 2'h0) || (sel == 1 && fail_safe_reg === 1'b1) ||
        (sel == 2 && cpu_resume_reg === 1'b1);
    end
    // A wait that runs out counts as a mismatch
    if (!hit) begin
      miscompares++;
      $display("[ERR] %0t ns: wait %0d timed out", $time, sel);
    end
  endtask
  // Counts, verdict, end of run
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests and watchdog
  // ----------------------------------------
  initial begin
    #400000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge pclk);
    chk(32'(clk_sel_reg), 32'h2);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(clk_sel_reg), 32'h2);
    chk(32'(primary_osc_en_reg), 32'h1);
    rd_chk(`FSCR_OFS_CONFIG, 32'h19);
    rd_chk(`FSCR_OFS_OSC_CTRL, 32'h0);
    rd_chk(12'h010, 32'h0);
    chk(32'(last_err), 32'h1);
    wait_on(0, 12000);
    chk(32'(clk_sel_reg), 32'h0);
    rd_chk(`FSCR_OFS_OSC_CTRL, 32'h8);
    $display("test start-up done");
    osc_run <= 1'b0;
    wait_on(1, 300);
    chk(32'(clk_sel_reg), 32'h2);
    chk(32'(watchdog_clear_reg), 32'h1);
    rd_chk(`FSCR_OFS_STATUS, 32'h3);
    rd_chk(`FSCR_OFS_OSC_CTRL, 32'h0);
    osc_run <= 1'b1;
    repeat (500) @(posedge pclk);
    chk(32'(clk_sel_reg), 32'h2);
    apb(1'b1, `FSCR_OFS_STATUS, 32'h1);
    rd_chk(`FSCR_OFS_STATUS, 32'h2);
    $display("test failure done");
    apb(1'b1, `FSCR_OFS_CONFIG, 32'h09);
    apb(1'b1, `FSCR_OFS_COMMAND, 32'h3);
    @(posedge pclk);
    chk(32'(clk_sel_reg), 32'h0);
    chk(32'(fail_safe_reg), 32'h0);
    rd_chk(`FSCR_OFS_COMMAND, 32'h2);
    rd_chk(`FSCR_OFS_STATUS, 32'h10);
    osc_run <= 1'b0;
    wait_on(1, 300);
    chk(32'(fail_safe_reg), 32'h1);
    rd_chk(`FSCR_OFS_STATUS, 32'h1b);
    apb(1'b1, `FSCR_OFS_COMMAND, 32'h10);
    wait_on(2, 5);
    chk(32'(cpu_resume_reg), 32'h1);
    $display("test idle failure done");
    osc_run <= 1'b1;
    apb(1'b1, `FSCR_OFS_OSC_CTRL, 32'h2);
    apb(1'b1, `FSCR_OFS_CONFIG, 32'h0c);
    apb(1'b1, `FSCR_OFS_COMMAND, 32'h5);
    @(posedge pclk);
    chk(32'(clk_sel_reg), 32'h2);
    apb(1'b1, `FSCR_OFS_COMMAND, 32'h8);
    wait_on(0, 10);
    chk(32'(clk_sel_reg), 32'h0);
    osc_run <= 1'b0;
    wait_on(1, 300);
    chk(32'(fail_safe_reg), 32'h1);
    $display("test wake done");
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3000) @(posedge pclk);
    chk(32'(clk_sel_reg), 32'h2);
    chk(32'(fail_safe_reg), 32'h0);
    rd_chk(`FSCR_OFS_STATUS, 32'h4);
    rd_chk(`FSCR_OFS_OSC_CTRL, 32'h0);
    apb(1'b1, `FSCR_OFS_COMMAND, 32'h3);
    @(posedge pclk);
    chk(32'(primary_osc_en_reg), 32'h0);
    wait_on(1, 300);
    chk(32'(clk_sel_reg), 32'h2);
    $display("test never ready done");
    osc_run <= 1'b1;
    apb(1'b1, `FSCR_OFS_OSC_CTRL, 32'h2);
    apb(1'b1, `FSCR_OFS_CONFIG, 32'h0d);
    apb(1'b1, `FSCR_OFS_COMMAND, 32'h5);
    apb(1'b1, `FSCR_OFS_COMMAND, 32'h8);
    // Short of the oscillator edge count, so still on the internal clock
    repeat (8000) @(posedge pclk);
    chk(32'(clk_sel_reg), 32'h2);
    wait_on(0, 2000);
    chk(32'(clk_sel_reg), 32'h0);
    rd_chk(`FSCR_OFS_OSC_CTRL, 32'ha);
    $display("test pll start-up done");
    wrap_up;
  end
endmodule // fscr_clock_recovery_tb
bind fscr_clock_recovery fscr_clock_recovery_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .clk_sel_reg(clk_sel_reg),
  .primary_osc_en_reg(primary_osc_en_reg), .watchdog_clear_reg(watchdog_clear_reg),
  .cpu_resume_reg(cpu_resume_reg), .fail_safe_reg(fail_safe_reg));
`default_nettype wire

//--- test/fscr_osc_model.sv
// Primary oscillator model standing at the crystal pins
`timescale 1ns/1ps
`default_nettype none
module fscr_osc_model (
  // Control
  input wire logic enable,
  input wire logic running,
  // Clock pin
  output logic osc_clk
);
  // Toggles only while powered and healthy, else stands low
  initial osc_clk = 1'b0;
  always #40 osc_clk = (enable && running) ? ~osc_clk : 1'b0;
endmodule // fscr_osc_model
`default_nettype wire
